// File: hdl/gdl_pkg.sv
/*
  Package for the gamma latch control block: channel counts, code layout,
  bus address constants, command fields and the byte carrier struct.
  Assumes a single 200 MHz clock domain; no bus registers are exposed.
*/
package gdl_pkg;

  // ****************************************************************
  // Channel layout
  // ****************************************************************
  localparam int unsigned GDL_NUM_GAMMA  = 18;                 // Gamma channels
  localparam int unsigned GDL_NUM_COMMON = 2;                  // Common-voltage channels
  localparam int unsigned GDL_NUM_CH     = GDL_NUM_GAMMA + GDL_NUM_COMMON;
  localparam int unsigned GDL_CODE_W     = 10;                 // Code width
  localparam int unsigned GDL_CH_W       = 5;                  // Channel index width
  localparam logic [9:0]  GDL_CODE_MID   = 10'h200;            // Midpoint, 512 of 1024
  localparam logic [4:0]  GDL_CH_LAST    = 5'h13;              // Highest valid channel

  // ****************************************************************
  // Bus constants
  // ****************************************************************
  localparam logic [6:0]  GDL_DEV_ADDR   = 7'h3a;              // Write byte 74h
  localparam logic [7:0]  GDL_GC_ADDR    = 8'h00;              // General call address
  localparam logic [7:0]  GDL_GC_RESET   = 8'h06;              // General call reset data
  localparam logic [2:0]  GDL_CMD_WRITE  = 3'h0;               // Plain channel write
  localparam logic [2:0]  GDL_CMD_ALLRST = 3'h4;               // Reset all channels
  localparam logic [2:0]  GDL_CMD_CHRST  = 3'h2;               // Reset one channel
  localparam int unsigned GDL_UPD_BIT    = 15;                 // Software update bit
  localparam logic [3:0]  GDL_BIT_LAST   = 4'h7;               // Last bit index of a byte

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [GDL_CODE_W-1:0] gdl_code_t;

  // Received byte handed from the bus receiver to the control logic
  typedef struct packed {
    logic       valid;  // One-cycle pulse: byte complete (before ack slot)
    logic       first;  // Byte follows a start condition
    logic [7:0] data;   // Byte value, MSB first on the wire
  } gdl_byte_s;

  // Receiver framing events
  typedef struct packed {
    logic start;        // Start or repeated start seen
    logic stop;         // Stop seen
  } gdl_frame_s;

  // Control state machine
  typedef enum logic [5:0] {
    GDL_IDLE  = 6'b000001,  // Waiting for address byte
    GDL_GCALL = 6'b000010,  // General call address taken
    GDL_CMD   = 6'b000100,  // Waiting for channel address byte
    GDL_MSB   = 6'b001000,  // Waiting for high data byte
    GDL_LSB   = 6'b010000,  // Waiting for low data byte
    GDL_IGN   = 6'b100000   // Not addressed; ignore until stop/start
  } gdl_state_e;

endpackage : gdl_pkg

// File: hdl/gdl_bus_rx.sv
/*
  Two-wire slave bit receiver: synchronises the pins, finds start and stop,
  shifts bytes in and drives the acknowledge slot when told to.
  Assumes bus clock far below 200 MHz so that two-flop sampling suffices.
*/
`timescale 1ns/100ps
module gdl_bus_rx
  import gdl_pkg::*;
(
  input  wire logic       clk_in,       // 200 MHz clock
  input  wire logic       rstn_in,      // Synchronous reset, active low
  input  wire logic       ce_in,        // Clock enable
  input  wire logic       scl_in,       // Serial clock pin
  input  wire logic       sda_in,       // Serial data pin
  input  wire logic       ack_in,       // Ack the byte just delivered
  output gdl_byte_s       byte_out,     // Received byte
  output gdl_frame_s      frame_out,    // Start/stop events
  output logic            sda_oe_out    // Pull data low while high
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] scl_sync_q;   // Two-flop chain for clock pin
  logic [1:0] sda_sync_q;   // Two-flop chain for data pin
  logic       scl_q;        // Delayed synchronised clock
  logic       sda_q;        // Delayed synchronised data
  logic [3:0] bit_cnt_q;    // Bit position within the byte
  logic [7:0] shift_q;      // Shift register
  logic       in_ack_q;     // Inside the acknowledge slot
  logic       first_q;      // Next byte is first after start
  logic       ack_q;        // Ack requested for current slot

  // Edge decode, read only from second flops onwards
  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_end = scl_rise & ~in_ack_q & (bit_cnt_q == GDL_BIT_LAST);

  // Synchronise and delay the pins
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'h1;
      sda_q      <= 1'h1;
    end else if (ce_in) begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_q      <= scl_s;
      sda_q      <= sda_s;
    end
  end

  // ****************************************************************
  // Byte shifter and ack slot
  // ****************************************************************
  // Bits are taken on the clock rise; the ack drive changes on the fall
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      in_ack_q   <= 1'h0;
      first_q    <= 1'h0;
      ack_q      <= 1'h0;
      sda_oe_out <= 1'h0;
      byte_out   <= '0;
      frame_out  <= '0;
    end else if (ce_in) begin
      byte_out.valid <= 1'h0;
      frame_out      <= '{start: start_ev, stop: stop_ev};
      if (start_ev || stop_ev) begin
        // Framing resets the bit counter and releases data
        bit_cnt_q  <= 4'h0;
        in_ack_q   <= 1'h0;
        first_q    <= start_ev;
        sda_oe_out <= 1'h0;
      end else if (scl_rise && !in_ack_q) begin
        shift_q   <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (byte_end) begin
          byte_out <= '{valid: 1'h1, first: first_q, data: {shift_q[6:0], sda_s}};
          first_q  <= 1'h0;
        end
      end else if (scl_fall) begin
        if (bit_cnt_q == GDL_BIT_LAST + 4'h1 && !in_ack_q) begin
          // Enter ack slot; control has answered by now
          in_ack_q   <= 1'h1;
          sda_oe_out <= ack_q;
        end else if (in_ack_q) begin
          in_ack_q   <= 1'h0;
          bit_cnt_q  <= 4'h0;
          sda_oe_out <= 1'h0;
        end
      end
      if (byte_out.valid) begin
        ack_q <= ack_in;
      end
    end
  end

endmodule : gdl_bus_rx

// File: hdl/gdl_latch_ctrl.sv
/*
  Gamma latch control top: storage and output code registers for twenty
  channels, write decode from the two-wire receiver, reset commands and
  the latch pin / software update transfer.
  Assumes the converter reads the output codes continuously.
*/
`timescale 1ns/100ps
// Contract
// - Eighteen gamma plus two common channels, 10-bit
// - Storage and output register per channel
// - General call 00h then 06h resets all
// - Ack general call address; nack other data
// - Power-up reset loads midpoint everywhere
// - Command bits 100 reset all channels
// - Command bits 010 reset addressed channel
// - Codes are unsigned fraction of reference span
// - Latch low: output follows storage write
// - Latch high holds; falling edge transfers all
// - Bit 15 set transfers all after word
// - Resets update outputs regardless of latch; channel reset (010) updates the output only while latch is low
// - Respond at slave address 74h
// - Common channels writable independently
// - Only channels 00000 to 10011 acknowledged
// - Store only after second data byte
// - Auto-increment channel after each word
module gdl_latch_ctrl
  import gdl_pkg::*;
(
  input  wire logic                 clk_in,          // 200 MHz clock
  input  wire logic                 rstn_in,         // Synchronous reset, active low
  input  wire logic                 ce_in,           // Clock enable
  input  wire logic                 scl_in,          // Serial clock pin
  input  wire logic                 sda_in,          // Serial data pin
  input  wire logic                 load_latch_pin,  // Latch pin, high holds outputs
  output logic                      sda_oe_out,      // Data pin pull-low enable
  output gdl_code_t [GDL_NUM_CH-1:0] dac_code_out,   // Output codes to converter
  output logic                      update_out       // Pulse: outputs reloaded
);

  // ****************************************************************
  // Receiver
  // ****************************************************************
  gdl_byte_s  rx_byte;   // Received byte
  gdl_frame_s rx_frame;  // Start/stop events
  logic       ack_d;     // Ack decision for current byte

  gdl_bus_rx u_rx (
    .clk_in     (clk_in),
    .rstn_in    (rstn_in),
    .ce_in      (ce_in),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .ack_in     (ack_d),
    .byte_out   (rx_byte),
    .frame_out  (rx_frame),
    .sda_oe_out (sda_oe_out)
  );

  // ****************************************************************
  // State and storage
  // ****************************************************************
  gdl_state_e             state_q;              // Control state
  gdl_state_e             state_d;              // Next state
  logic [GDL_CH_W-1:0]    ch_q;                 // Current channel
  logic [7:0]             msb_q;                // Held high data byte
  logic [2:0]             cmd_q;                // Command bits of address byte
  gdl_code_t              store_q [GDL_NUM_CH]; // Storage registers
  logic [1:0]             ld_sync_q;            // Latch pin synchroniser
  logic                   ld_q;                 // Delayed synchronised latch
  logic                   por_q;                // Power-up reset not yet done

  // Byte decode
  wire        bv        = rx_byte.valid;
  wire [7:0]  bd        = rx_byte.data;
  wire        addr_hit  = bd == {GDL_DEV_ADDR, 1'b0};
  wire        ch_ok     = bd[4:0] <= GDL_CH_LAST;
  wire [2:0]  cmd_in    = bd[7:5];
  // Word complete only on second data byte
  wire        word_done = bv && state_q == GDL_LSB;
  wire        gc_reset  = bv && state_q == GDL_GCALL && bd == GDL_GC_RESET;
  wire        all_rst   = bv && state_q == GDL_CMD && ch_ok && cmd_in == GDL_CMD_ALLRST;
  wire        ch_rst    = word_done && cmd_q == GDL_CMD_CHRST;
  wire        ch_wr     = word_done && cmd_q == GDL_CMD_WRITE;
  wire        sw_upd    = ch_wr && msb_q[GDL_UPD_BIT-8];
  // Latch falling edge from second flop
  wire        ld_s      = ld_sync_q[1];
  wire        ld_fall   = ld_q & ~ld_s;
  wire        full_rst  = gc_reset | por_q | all_rst;
  wire        xfer_all  = ld_fall | sw_upd;
  wire [GDL_CODE_W-1:0] wr_code = {msb_q[1:0], bd};

  // ****************************************************************
  // Byte sequencing
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    ack_d   = 1'b0;
    case (state_q)
      GDL_IDLE, GDL_IGN: begin
        if (bv && rx_byte.first) begin
          // Always ack the general call address
          if (bd == GDL_GC_ADDR) begin
            state_d = GDL_GCALL;
            ack_d   = 1'b1;
          end else if (addr_hit) begin
            state_d = GDL_CMD;
            ack_d   = 1'b1;
          end else begin
            state_d = GDL_IGN;
          end
        end
      end
      GDL_GCALL: begin
        if (bv) begin
          // Only the reset data byte is acked
          ack_d   = bd == GDL_GC_RESET;
          state_d = GDL_IGN;
        end
      end
      GDL_CMD: begin
        if (bv) begin
          ack_d   = ch_ok;
          state_d = ch_ok && cmd_in != GDL_CMD_ALLRST ? GDL_MSB : GDL_IGN;
        end
      end
      GDL_MSB: begin
        if (bv) begin
          ack_d   = 1'b1;
          state_d = GDL_LSB;
        end
      end
      GDL_LSB: begin
        if (bv) begin
          ack_d   = 1'b1;
          state_d = GDL_MSB;
        end
      end
      default: state_d = GDL_IDLE;
    endcase
    // Start or stop abandons a partial word
    if (rx_frame.start || rx_frame.stop) begin
      state_d = GDL_IDLE;
    end
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_q   <= GDL_IDLE;
      ch_q      <= '0;
      msb_q     <= 8'h00;
      cmd_q     <= GDL_CMD_WRITE;
      // Cleared so a pin held low through reset gives no false fall
      ld_sync_q <= '0;
      ld_q      <= 1'h0;
      por_q     <= 1'h1;
    end else if (ce_in) begin
      state_q   <= state_d;
      ld_sync_q <= {ld_sync_q[0], load_latch_pin};
      ld_q      <= ld_s;
      por_q     <= 1'h0;
      if (bv && state_q == GDL_CMD) begin
        ch_q  <= bd[4:0];
        cmd_q <= cmd_in;
      end
      if (bv && state_q == GDL_MSB) begin
        msb_q <= bd;
      end
      // Advance, wrapping after the last channel
      if (word_done) begin
        ch_q <= (ch_q == GDL_CH_LAST) ? '0 : ch_q + 5'h01;
      end
    end
  end

  // ****************************************************************
  // Channel registers
  // ****************************************************************
  // One storage/output pair per channel, each addressed alone
  // Codes are kept as plain unsigned binary for the converter
  for (genvar c = 0; c < GDL_NUM_CH; c++) begin : g_ch
    wire hit = ch_q == GDL_CH_W'(c);
    always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
        store_q[c]      <= GDL_CODE_MID;
        dac_code_out[c] <= GDL_CODE_MID;
      end else if (ce_in) begin
        if (full_rst) begin
          store_q[c]      <= GDL_CODE_MID;
          dac_code_out[c] <= GDL_CODE_MID;
        end else if (ch_rst && hit) begin
          // Reset one channel; follows latch like a write
          store_q[c] <= GDL_CODE_MID;
          if (!ld_s) begin
            dac_code_out[c] <= GDL_CODE_MID;
          end
        end else if (ch_wr && hit) begin
          // Store; pass straight on while latch low
          store_q[c] <= wr_code;
          if (!ld_s || sw_upd) begin
            dac_code_out[c] <= wr_code;
          end
        end else if (xfer_all) begin
          dac_code_out[c] <= store_q[c];
        end
      end
    end
  end

  // Update indication
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      update_out <= 1'h0;
    end else if (ce_in) begin
      update_out <= full_rst | xfer_all;
    end
  end

endmodule : gdl_latch_ctrl

// File: sim/gdl_bus_master.sv
/*
  Two-wire bus master model standing in for the panel timing controller.
  Assumes a pull-up on the data wire: it is low when either side pulls it.
*/
`timescale 1ns/100ps
module gdl_bus_master #(
  parameter int HALF = 10  // Clock cycles per half bus period
) (
  input  wire logic clk_in,   // Bench clock
  input  wire logic sda_in,   // Resolved data wire level
  output logic      scl_out,  // Bus clock, idles high
  output logic      sda_out   // High releases the data wire
);
  // ************************************************************
  // Bus primitives
  // ************************************************************
  // Bus idles released, so the wire floats to the pull-up level
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Changes land on falling edges, away from the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_out = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_out = 1'b0;
    tick(HALF);
    scl_out = 1'b0;
  endtask : start

  // One bit; data moves a few cycles after the clock falls, for hold
  task automatic put_bit(input logic b);
    tick(4);
    sda_out = b;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
  endtask : put_bit

  // Byte MSB first, then the ninth clock with the wire released
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    tick(4);
    sda_out = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF - 1);
    ack = ~sda_in;
    tick(1);
    scl_out = 1'b0;
  endtask : wr_byte

  // Stop: data rises while the clock is high
  task automatic stop();
    tick(4);
    sda_out = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_out = 1'b1;
    tick(HALF);
  endtask : stop
endmodule : gdl_bus_master

// File: sim/gdl_latch_ctrl_props.sv
/*
  Checker for the latch control top: reset state, transfer pulses and
  acknowledge timing. Sees only the top ports; bound at the foot.
*/
`timescale 1ns/100ps
module gdl_latch_ctrl_props
  import gdl_pkg::*;
(
  input wire logic                       clk_in,
  input wire logic                       rstn_in,
  input wire logic                       ce_in,
  input wire logic                       scl_in,
  input wire logic                       sda_in,
  input wire logic                       load_latch_pin,
  input wire logic                       sda_oe_out,
  input wire gdl_code_t [GDL_NUM_CH-1:0] dac_code_out,
  input wire logic                       update_out
);
  // ************************************************************
  // Helper: latch-high age, long enough to cover the pin synchroniser
  // ************************************************************
  logic [2:0] hi_cnt_q;  // Saturating count of high samples
  logic [2:0] hi_cnt_d;  // Next count
  assign hi_cnt_d = !load_latch_pin ? 3'h0 : (hi_cnt_q == 3'h7) ? hi_cnt_q : hi_cnt_q + 3'h1;
  // Short register; reset clears so mid-run resets start fresh
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hi_cnt_q <= 3'h0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // ************************************************************
  // Assertions
  // ************************************************************
  a_reset_vals: assert property ($rose(rstn_in) |->
    dac_code_out == {GDL_NUM_CH{GDL_CODE_MID}} && !sda_oe_out)
    else $error("codes or ack not at reset state");
  a_pwrup_pulse: assert property ($rose(rstn_in) |-> ##[0:3] update_out)
    else $error("no reload pulse after reset");
  a_upd_single: assert property (update_out |=> !update_out)
    else $error("reload pulse longer than one cycle");
  a_latch_xfer: assert property ($fell(load_latch_pin) |-> ##[1:8] update_out)
    else $error("latch fall gave no transfer");
  a_latch_hold: assert property (
    hi_cnt_q == 3'h7 && $changed(dac_code_out) |-> update_out)
    else $error("output changed while latched");
  a_ack_rise: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("ack raised with bus clock high");
  a_ack_fall: assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("ack dropped with bus clock high");
  a_oe_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data pull moved while bus clock high");

  c_update: cover property (update_out);
  c_ack: cover property ($rose(sda_oe_out));
  c_soft_xfer: cover property (hi_cnt_q == 3'h7 && update_out);
endmodule : gdl_latch_ctrl_props

bind gdl_latch_ctrl gdl_latch_ctrl_props u_props (
  .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .scl_in(scl_in), .sda_in(sda_in),
  .load_latch_pin(load_latch_pin), .sda_oe_out(sda_oe_out), .dac_code_out(dac_code_out),
  .update_out(update_out));

// File: sim/gdl_latch_ctrl_tb_top.sv
/*
  Self-checking bench for the latch control top: bus writes, refusals,
  latch and software transfers, reset commands and the general call.
  Assumes a pull-up on the data wire, modelled by a wired AND.
*/
`timescale 1ns/100ps
module gdl_latch_ctrl_tb_top;
  import gdl_pkg::*;
  logic                        clk;     // 200 MHz bench clock
  logic                        rstn;    // Synchronous reset, active low
  logic                        latch;   // Latch pin
  logic                        scl;     // Bus clock from master
  logic                        sda_m;   // Master data, high releases
  logic                        sda_oe;  // Device pulls data low
  logic                        upd;     // Reload pulse
  gdl_code_t [GDL_NUM_CH-1:0]  code;    // Output codes
  wire                         sda_w = sda_m & ~sda_oe;  // Wire level
  int                          errors = 0;
  int                          num_checks = 0;

  // Free-running clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Clock enable tied on: freezing is not exercised here
  gdl_latch_ctrl u_dut (.clk_in(clk), .rstn_in(rstn), .ce_in(1'b1), .scl_in(scl),
    .sda_in(sda_w), .load_latch_pin(latch), .sda_oe_out(sda_oe), .dac_code_out(code),
    .update_out(upd));
  gdl_bus_master u_mst (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // One framed transfer; byte at index nak must be refused, all others taken
  task automatic frame(input logic [7:0] bs[$], input int nak);
    logic a;
    u_mst.start();
    foreach (bs[i]) begin
      u_mst.wr_byte(bs[i], a);
      chk(16'(a), 16'(i != nak));
    end
    u_mst.stop();
  endtask : frame

  // Bounded wait for the reload pulse
  task automatic wait_upd();
    int n;
    n = 0;
    while (upd !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (upd !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask : wait_upd

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rstn = 1'b0;
    latch = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(code[0]), 16'h200);
    chk(16'(code[19]), 16'h200);
    $display("test reset done");
    frame('{8'h74, 8'h03, 8'h01, 8'h55}, -1);
    chk(16'(code[3]), 16'h155);
    // Auto-increment across the common channels and the wrap to zero
    frame('{8'h74, 8'h12, 8'h00, 8'haa, 8'h03, 8'hff, 8'h00, 8'h11}, -1);
    chk(16'(code[18]), 16'h0aa);
    chk(16'(code[19]), 16'h3ff);
    chk(16'(code[0]), 16'h011);
    $display("test write done");
    frame('{8'h76}, 0);
    frame('{8'h74, 8'h14}, 1);
    frame('{8'h74, 8'h05, 8'h01}, -1);
    chk(16'(code[5]), 16'h200);
    $display("test refuse done");
    // Preload with the pin high, then release it
    latch = 1'b1;
    frame('{8'h74, 8'h01, 8'h01, 8'h23}, -1);
    chk(16'(code[1]), 16'h200);
    latch = 1'b0;
    wait_upd();
    chk(16'(code[1]), 16'h123);
    @(negedge clk);
    chk(16'(upd), 16'h0);
    latch = 1'b1;
    frame('{8'h74, 8'h02, 8'h00, 8'hf0}, -1);
    chk(16'(code[2]), 16'h200);
    frame('{8'h74, 8'h03, 8'h82, 8'hcc}, -1);
    chk(16'(code[2]), 16'h0f0);
    chk(16'(code[3]), 16'h2cc);
    latch = 1'b0;
    $display("test latch done");
    frame('{8'h74, 8'h43, 8'h00, 8'h00}, -1);
    chk(16'(code[3]), 16'h200);
    chk(16'(code[2]), 16'h0f0);
    frame('{8'h74, 8'h92}, -1);
    chk(16'(code[18]), 16'h200);
    chk(16'(code[2]), 16'h200);
    $display("test channel reset done");
    frame('{8'h74, 8'h00, 8'h00, 8'h11}, -1);
    latch = 1'b1;
    frame('{8'h00, 8'h05}, 1);
    chk(16'(code[0]), 16'h011);
    frame('{8'h00, 8'h06}, -1);
    chk(16'(code[0]), 16'h200);
    latch = 1'b0;
    $display("test general call done");
    summarize();
  end
endmodule : gdl_latch_ctrl_tb_top
